// ===== logic/sffr_flags.sv
// latched error and warning flags with apb register access
// Function
// - warning word reads identifier 1011 in bits 15 to 12
// - warning flags latch until host reads and clears them
// - error bit 5 on uncorrectable memory fault at post-reset load only
// - warning bit 5 on corrected memory fault at post-reset load only
// - error bit 4 when either oscillator watchdog trips
// - error bit 3 set repeatedly while supply undervoltage persists
// - error bit 2 set repeatedly while regulator undervoltage persists
// - error bit 1 when field below configurable low limit
// - error bit 0 on power-on or hard reset, not on self-test
// - warning bit 11 on bad bit count, bit 15 set, or line-code error
// - warning bit 10 on checksum error only when checking enabled
// - warning bit 8 while output slew limiting is applied
// - warning bit 7 when an extended-write command fails
// - warning bit 6 when temperature outside -60 to 180 C, clamp it
// - warning bit 4 when any signal-chain value saturated
// - warning bit 3 when successive zero-cross angles differ over 135 degrees
// - warning bit 2 when extended access starts before previous finished
// - warning bit 1 when field above configurable high limit
// - warning bit 0 when turns count exceeds +255/-256 rotations
// - turns overflow cleared only by turns-count reset command
// - error word reads identifier 1010 and errors latch until cleared
// - error bit 11 shows unmasked warnings unless summary masked
// - angle-word error indicator high on any unmasked error or warning
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
module sffr_flags
  import sffr_pkg::*;
#(
  parameter int unsigned FIELD_W = 12
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // memory load and clock/supply monitors
  input wire logic nvm_load_done,
  input wire logic nvm_uncorrectable_err,
  input wire logic nvm_corrected_warn,
  input wire logic hf_osc_trip,
  input wire logic lf_osc_trip,
  input wire logic supply_undervolt_err,
  input wire logic regulator_undervolt_err,
  // measurements
  input wire logic field_valid,
  input wire logic [FIELD_W-1:0] field_gauss,
  input wire logic temp_valid,
  input wire logic signed [11:0] temp_raw,
  input wire logic zero_cross_valid,
  input wire logic [11:0] zero_cross_angle,
  input wire logic turn_eighth_mode,
  input wire logic signed [11:0] turn_count,
  // serial and extended command events
  input wire logic pkt_bad_length,
  input wire logic pkt_bit15_set,
  input wire logic line_code_err,
  input wire logic pkt_crc_bad,
  input wire logic slew_limit_active,
  input wire logic ext_cmd_fail,
  input wire logic saturation_warn,
  input wire logic ext_access_start,
  input wire logic ext_access_busy,
  // outputs
  output logic error_summary_bit,
  output logic pkt_discard,
  output logic signed [11:0] temp_clamped
);
  import sffr_pkg::*;

  logic [11:0] err_q, err_d;
  logic [11:0] warn_q, warn_d;
  logic [11:0] mask_err_q, mask_err_d;
  logic [11:0] mask_warn_q, mask_warn_d;
  logic [31:0] cfg_q, cfg_d;
  logic [31:0] lim_q, lim_d;
  logic boot_q, boot_d;
  logic [11:0] zc_prev_q, zc_prev_d;
  logic zc_have_q, zc_have_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic sum_q, sum_d;
  logic disc_q, disc_d;
  logic signed [11:0] temp_q, temp_d;

  logic [7:0] idx;
  logic wr, rd, hit;
  logic clr_err, clr_warn, turn_rst;
  logic [11:0] err_set, warn_set;
  logic [11:0] zc_diff;
  logic [FIELD_W-1:0] lim_lo, lim_hi;
  logic turn_ovf, temp_lo, temp_hi;

  assign idx = paddr[9:2];
  assign lim_lo = lim_q[FIELD_W-1:0];
  assign lim_hi = lim_q[LIM_HI_LSB +: FIELD_W];

  always_comb begin
    // access phase, answered after one wait state
    wr = psel && penable && pwrite && !pready_q;
    rd = psel && penable && !pwrite && !pready_q;
    hit = (idx == IDX_ERR) || (idx == IDX_WARN) || (idx == IDX_CTRL) ||
          (idx == IDX_MASK) || (idx == IDX_CFG) || (idx == IDX_LIMIT);
    clr_err = wr && (idx == IDX_CTRL) && pwdata[C_CLR_ERR];
    clr_warn = wr && (idx == IDX_CTRL) && pwdata[C_CLR_WARN];
    turn_rst = wr && (idx == IDX_CTRL) && pwdata[C_TURN_RST];
  end

  // fault causes seen this cycle
  always_comb begin
    zc_diff = zero_cross_angle - zc_prev_q;
    if (zc_diff[11]) begin
      zc_diff = 12'h000 - zc_diff;
    end
    if (turn_eighth_mode) begin
      turn_ovf = (turn_count == TURN_EIGHTH_MAX) || (turn_count == TURN_EIGHTH_MIN);
    end else begin
      turn_ovf = (turn_count > TURN_HALF_MAX) || (turn_count < TURN_HALF_MIN);
    end
    temp_lo = temp_raw < TEMP_MIN;
    temp_hi = temp_raw > TEMP_MAX;

    err_set = 12'h000;
    err_set[E_NVM] = boot_q && nvm_load_done && nvm_uncorrectable_err;
    err_set[E_OSC] = hf_osc_trip || lf_osc_trip;
    err_set[E_UVD] = supply_undervolt_err;
    err_set[E_UVA] = regulator_undervolt_err;
    err_set[E_MSL] = field_valid && (field_gauss < lim_lo);

    warn_set = 12'h000;
    warn_set[W_IER] = pkt_bad_length || pkt_bit15_set || line_code_err;
    warn_set[W_CRC] = cfg_q[G_CRC_EN] && pkt_crc_bad;
    warn_set[W_SRW] = slew_limit_active;
    warn_set[W_XEE] = ext_cmd_fail;
    warn_set[W_TR] = temp_valid && (temp_lo || temp_hi);
    warn_set[W_ESE] = boot_q && nvm_load_done && nvm_corrected_warn;
    warn_set[W_SAT] = saturation_warn;
    warn_set[W_TCW] = zero_cross_valid && zc_have_q && (zc_diff > STEP_MAX);
    warn_set[W_BSY] = ext_access_start && ext_access_busy;
    warn_set[W_MSH] = field_valid && (field_gauss > lim_hi);
    warn_set[W_TOV] = turn_ovf;
  end

  // warning word: clear first, then this cycle's causes, so set wins
  always_comb begin
    warn_d = warn_q;
    if (clr_warn) begin
      // turn overflow survives an ordinary clear
      warn_d = warn_q & (12'h001 << W_TOV);
    end
    if (turn_rst) begin
      warn_d[W_TOV] = 1'b0;
    end
    // reserved bit 9 never latches
    warn_d = (warn_d | warn_set) & WARN_USED;
  end

  // only a host clear or a turns reset lowers a warning
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warn_q <= 12'h000;
    end else begin
      warn_q <= warn_d;
    end
  end

  // error word: same set-wins order as the warnings
  always_comb begin
    err_d = err_q;
    if (clr_err) begin
      err_d = 12'h000;
    end
    err_d = (err_d | err_set) & ~(12'h001 << E_WAR);
    // bit 11 follows the new warning word live, never latched
    err_d[E_WAR] = |(warn_d & ~mask_warn_q) && !cfg_q[G_WAR_MASK];
  end

  // reset flag marks re-initialised volatile state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_q <= 12'h001 << E_RST;
    end else begin
      err_q <= err_d;
    end
  end

  // boot window closes at the first finished memory load
  always_comb begin
    boot_d = boot_q && !nvm_load_done;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_q <= 1'b1;
    end else begin
      boot_q <= boot_d;
    end
  end

  // last zero-cross sample for the step check
  always_comb begin
    zc_have_d = zc_have_q || zero_cross_valid;
    zc_prev_d = zc_prev_q;
    if (zero_cross_valid) begin
      zc_prev_d = zero_cross_angle;
    end
  end

  // no step check until a first sample exists
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zc_prev_q <= 12'h000;
      zc_have_q <= 1'b0;
    end else begin
      zc_prev_q <= zc_prev_d;
      zc_have_q <= zc_have_d;
    end
  end

  // host-written masks, configuration and field limits
  always_comb begin
    mask_err_d = mask_err_q;
    mask_warn_d = mask_warn_q;
    cfg_d = cfg_q;
    lim_d = lim_q;
    if (wr && (idx == IDX_MASK)) begin
      mask_err_d = pwdata[11:0];
      mask_warn_d = pwdata[27:16];
    end
    if (wr && (idx == IDX_CFG)) begin
      cfg_d = pwdata & 32'h0000_0003;
    end
    if (wr && (idx == IDX_LIMIT)) begin
      lim_d = pwdata;
    end
  end

  // masks reach only the summaries and error bit 11, never the latched flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_err_q <= 12'h000;
      mask_warn_q <= 12'h000;
    end else begin
      mask_err_q <= mask_err_d;
      mask_warn_q <= mask_warn_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= CFG_RST;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // limits packed low in the low half, high in the upper half
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lim_q <= {4'h0, FIELD_HI_DEF, 4'h0, FIELD_LO_DEF};
    end else begin
      lim_q <= lim_d;
    end
  end

  // summary, packet discard and clamped temperature
  always_comb begin
    logic err_any;
    logic warn_any;
    err_any = |(err_d & ~mask_err_q);
    warn_any = |(warn_d & ~mask_warn_q);
    sum_d = err_any || warn_any;
    disc_d = warn_set[W_IER] || warn_set[W_CRC];
    if (temp_lo) begin
      temp_d = TEMP_MIN;
    end else if (temp_hi) begin
      temp_d = TEMP_MAX;
    end else begin
      temp_d = temp_raw;
    end
  end

  // summary starts high: reset flag is pending
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sum_q <= 1'b1;
    end else begin
      sum_q <= sum_d;
    end
  end

  // discard pulse trails the bad packet by one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disc_q <= 1'b0;
    end else begin
      disc_q <= disc_d;
    end
  end

  // clamp applies whether or not the sample is flagged valid
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      temp_q <= 12'sd0;
    end else begin
      temp_q <= temp_d;
    end
  end

  // one wait state: answer on the edge after the first access edge
  always_comb begin
    logic [31:0] err_word;
    logic [31:0] warn_word;
    err_word = {16'h0000, ERR_ID, err_q};
    warn_word = {16'h0000, WARN_ID, warn_q};
    pready_d = psel && penable && !pready_q;
    pslverr_d = psel && penable && !pready_q && !hit;
    prdata_d = 32'h0000_0000;
    if (rd) begin
      if (idx == IDX_ERR) begin
        prdata_d = err_word;
      end else if (idx == IDX_WARN) begin
        prdata_d = warn_word;
      end else if (idx == IDX_MASK) begin
        prdata_d = {4'h0, mask_warn_q, 4'h0, mask_err_q};
      end else if (idx == IDX_CFG) begin
        prdata_d = cfg_q;
      end else if (idx == IDX_LIMIT) begin
        prdata_d = lim_q;
      end else begin
        prdata_d = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else begin
      prdata_q <= prdata_d;
    end
  end

  // ready stands one cycle so back-to-back transfers stay single
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= pready_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_q <= 1'b0;
    end else begin
      pslverr_q <= pslverr_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign error_summary_bit = sum_q;
  assign pkt_discard = disc_q;
  assign temp_clamped = temp_q;
endmodule

// ===== logic/sffr_pkg.sv
// constants for the sensor fault flag register block
package sffr_pkg;
  localparam int unsigned APB_AW = 8;
  // printed offsets are not all multiples of four: index, byte = 4*index
  localparam logic [7:0] IDX_ERR = 8'h24;
  localparam logic [7:0] IDX_WARN = 8'h26;
  localparam logic [7:0] IDX_CTRL = 8'h40;
  localparam logic [7:0] IDX_MASK = 8'h41;
  localparam logic [7:0] IDX_CFG = 8'h42;
  localparam logic [7:0] IDX_LIMIT = 8'h43;
  localparam logic [3:0] ERR_ID = 4'ha;
  localparam logic [3:0] WARN_ID = 4'hb;
  localparam int unsigned ID_LSB = 12;
  // error bit positions
  localparam int unsigned E_RST = 0;
  localparam int unsigned E_MSL = 1;
  localparam int unsigned E_UVA = 2;
  localparam int unsigned E_UVD = 3;
  localparam int unsigned E_OSC = 4;
  localparam int unsigned E_NVM = 5;
  localparam int unsigned E_WAR = 11;
  // warning bit positions
  localparam int unsigned W_TOV = 0;
  localparam int unsigned W_MSH = 1;
  localparam int unsigned W_BSY = 2;
  localparam int unsigned W_TCW = 3;
  localparam int unsigned W_SAT = 4;
  localparam int unsigned W_ESE = 5;
  localparam int unsigned W_TR = 6;
  localparam int unsigned W_XEE = 7;
  localparam int unsigned W_SRW = 8;
  localparam int unsigned W_CRC = 10;
  localparam int unsigned W_IER = 11;
  localparam logic [11:0] WARN_USED = 12'hdff;
  // control register bits
  localparam int unsigned C_CLR_ERR = 0;
  localparam int unsigned C_CLR_WARN = 1;
  localparam int unsigned C_TURN_RST = 2;
  // config register bits
  localparam int unsigned G_CRC_EN = 0;
  localparam int unsigned G_WAR_MASK = 1;
  localparam logic [31:0] CFG_RST = 32'h0000_0001;
  // field limits in gauss, default about 200 and 1200
  localparam logic [11:0] FIELD_LO_DEF = 12'h0c8;
  localparam logic [11:0] FIELD_HI_DEF = 12'h4b0;
  localparam int unsigned LIM_HI_LSB = 16;
  // temperature in 1/8 degree relative to 25 C: -60 C and 180 C
  localparam logic signed [11:0] TEMP_MIN = -12'sd680;
  localparam logic signed [11:0] TEMP_MAX = 12'sd1240;
  // 135 degrees in 12-bit angle units
  localparam logic [11:0] STEP_MAX = 12'h600;
  // turns count limits, half-turn and eighth-turn resolution
  localparam logic signed [11:0] TURN_HALF_MAX = 12'sd511;
  localparam logic signed [11:0] TURN_HALF_MIN = -12'sd512;
  localparam logic signed [11:0] TURN_EIGHTH_MAX = 12'sd2047;
  localparam logic signed [11:0] TURN_EIGHTH_MIN = -12'sd2048;
endpackage

// ===== verification/sffr_flags_props.sv
// assertion checker for the sensor fault flag registers
`timescale 1ns/1ps
module sffr_flags_props
  import sffr_pkg::*;
(
  // apb side
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  // fault sources
  input wire logic hf_osc_trip,
  input wire logic lf_osc_trip,
  input wire logic supply_undervolt_err,
  input wire logic regulator_undervolt_err,
  input wire logic pkt_bad_length,
  input wire logic pkt_bit15_set,
  input wire logic line_code_err,
  input wire logic temp_valid,
  input wire logic signed [11:0] temp_raw,
  // outputs watched
  input wire logic error_summary_bit,
  input wire logic pkt_discard,
  input wire logic signed [11:0] temp_clamped
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic rd_acc;
  assign rd_acc = psel && penable && !pwrite && !pready;

  AST_WARN_ID: assert property (rd_acc && paddr[9:2] == IDX_WARN |=> prdata[31:12] == {16'h0, WARN_ID})
    else $error("warning word id wrong");
  AST_ERR_ID: assert property (rd_acc && paddr[9:2] == IDX_ERR |=> prdata[31:12] == {16'h0, ERR_ID})
    else $error("error word id wrong");
  AST_UVD_HOLD: assert property (rd_acc && paddr[9:2] == IDX_ERR && $past(supply_undervolt_err) |=> prdata[E_UVD])
    else $error("supply undervolt not set");
  AST_UVA_HOLD: assert property (rd_acc && paddr[9:2] == IDX_ERR && $past(regulator_undervolt_err) |=> prdata[E_UVA])
    else $error("regulator undervolt not set");
  AST_OSC: assert property ((hf_osc_trip || lf_osc_trip) ##[1:6] (rd_acc && paddr[9:2] == IDX_ERR) |=> prdata[E_OSC])
    else $error("oscillator error lost");
  AST_DISCARD: assert property (pkt_bad_length || pkt_bit15_set || line_code_err |=> pkt_discard)
    else $error("bad packet kept");
  AST_TEMP_HI: assert property (temp_valid && temp_raw > TEMP_MAX |=> temp_clamped == TEMP_MAX)
    else $error("high temp not clamped");
  AST_TEMP_LO: assert property (temp_valid && temp_raw < TEMP_MIN |=> temp_clamped == TEMP_MIN)
    else $error("low temp not clamped");
  AST_SUMMARY: assert property (supply_undervolt_err |=> error_summary_bit)
    else $error("summary bit low");
  cover property (rd_acc && paddr[9:2] == IDX_WARN);
  cover property (pkt_discard);
  cover property (temp_valid && temp_raw < TEMP_MIN);
endmodule

bind sffr_flags sffr_flags_props u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .hf_osc_trip(hf_osc_trip), .lf_osc_trip(lf_osc_trip),
  .supply_undervolt_err(supply_undervolt_err), .regulator_undervolt_err(regulator_undervolt_err),
  .pkt_bad_length(pkt_bad_length), .pkt_bit15_set(pkt_bit15_set), .line_code_err(line_code_err),
  .temp_valid(temp_valid), .temp_raw(temp_raw), .error_summary_bit(error_summary_bit),
  .pkt_discard(pkt_discard), .temp_clamped(temp_clamped)
);

// ===== verification/sffr_flags_test.sv
// self-checking testbench for the sensor fault flag registers
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin error_cnt++; $display("mismatch %0t %h %h", $time, a, e); end end
module sffr_flags_test;
  import sffr_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [9:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rdat;
  logic pready, pslverr, error_summary_bit, pkt_discard, rerr;
  logic signed [11:0] temp_clamped, temp_raw = '0, turn_count = '0;
  logic nvm_load_done = 0, nvm_uncorrectable_err = 0, nvm_corrected_warn = 0, hf_osc_trip = 0, lf_osc_trip = 0;
  logic supply_undervolt_err = 0, regulator_undervolt_err = 0, pkt_bad_length = 0, pkt_bit15_set = 0;
  logic line_code_err = 0, pkt_crc_bad = 0, slew_limit_active = 0, ext_cmd_fail = 0, saturation_warn = 0;
  logic ext_access_start = 0, ext_access_busy = 0, zero_cross_valid = 0, turn_eighth_mode = 0;
  logic field_valid = 1'b1, temp_valid = 1'b1;
  logic [11:0] field_gauss = 12'h1f4, zero_cross_angle = 12'h000;
  int error_cnt = 0, check_count = 0;
  int pos[17] = '{E_OSC, E_OSC, E_UVD, E_UVA, E_MSL, W_IER, W_IER, W_IER, W_CRC, W_SRW, W_XEE, W_TR, W_TR,
    W_SAT, W_MSH, W_BSY, W_TCW};
  always #2 pclk = ~pclk;
  sffr_flags dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .nvm_load_done(nvm_load_done),
    .nvm_uncorrectable_err(nvm_uncorrectable_err), .nvm_corrected_warn(nvm_corrected_warn),
    .hf_osc_trip(hf_osc_trip), .lf_osc_trip(lf_osc_trip), .supply_undervolt_err(supply_undervolt_err),
    .regulator_undervolt_err(regulator_undervolt_err), .field_valid(field_valid), .field_gauss(field_gauss),
    .temp_valid(temp_valid), .temp_raw(temp_raw), .zero_cross_valid(zero_cross_valid),
    .zero_cross_angle(zero_cross_angle), .turn_eighth_mode(turn_eighth_mode), .turn_count(turn_count),
    .pkt_bad_length(pkt_bad_length), .pkt_bit15_set(pkt_bit15_set), .line_code_err(line_code_err),
    .pkt_crc_bad(pkt_crc_bad), .slew_limit_active(slew_limit_active), .ext_cmd_fail(ext_cmd_fail),
    .saturation_warn(saturation_warn), .ext_access_start(ext_access_start), .ext_access_busy(ext_access_busy),
    .error_summary_bit(error_summary_bit), .pkt_discard(pkt_discard), .temp_clamped(temp_clamped)
  );

  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      error_cnt++;
      wrap_up();
    end
    // answer taken at the ready edge, request released at it
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, '0);
    `CHK(rdat, exp)
  endtask

  // fault event k held one cycle, two for the zero-cross step k 16, then back to quiet inputs
  task automatic ev(input int k);
    @(posedge pclk);
    case (k)
      0: hf_osc_trip <= 1'b1;
      1: lf_osc_trip <= 1'b1;
      2: supply_undervolt_err <= 1'b1;
      3: regulator_undervolt_err <= 1'b1;
      4: field_gauss <= 12'h064;
      5: pkt_bad_length <= 1'b1;
      6: pkt_bit15_set <= 1'b1;
      7: line_code_err <= 1'b1;
      8: pkt_crc_bad <= 1'b1;
      9: slew_limit_active <= 1'b1;
      10: ext_cmd_fail <= 1'b1;
      11: temp_raw <= 12'sd2000;
      12: temp_raw <= -12'sd800;
      13: saturation_warn <= 1'b1;
      14: field_gauss <= 12'h5dc;
      15: {ext_access_start, ext_access_busy} <= 2'b11;
      16: begin
        zero_cross_valid <= 1'b1;
        @(posedge pclk);
        zero_cross_angle <= 12'h601;
      end
    endcase
    @(posedge pclk);
    {hf_osc_trip, lf_osc_trip, supply_undervolt_err, regulator_undervolt_err, pkt_bad_length, pkt_bit15_set,
      line_code_err, pkt_crc_bad, slew_limit_active, ext_cmd_fail, saturation_warn, ext_access_start} <= '0;
    {ext_access_busy, zero_cross_valid} <= 2'b00;
    field_gauss <= 12'h1f4;
    temp_raw <= '0;
  endtask

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      @(posedge pclk);
      {nvm_load_done, nvm_uncorrectable_err, nvm_corrected_warn} <= 3'b111;
      @(posedge pclk);
      {nvm_load_done, nvm_uncorrectable_err, nvm_corrected_warn} <= 3'b000;
      rd(IDX_ERR, i ? 32'h0000_a000 : 32'h0000_a821);
      rd(IDX_WARN, i ? 32'h0000_b000 : 32'h0000_b020);
      apb(1'b1, IDX_CTRL, 32'h0000_0003);
    end
    apb(1'b0, 8'h00, '0);
    `CHK({rerr, rdat, error_summary_bit}, {1'b1, 32'h0, 1'b0})
    $display("test boot done");
    for (int k = 0; k < 17; k++) begin
      ev(k);
      rd(IDX_ERR, k < 5 ? 32'h0000_a000 | (32'h1 << pos[k]) : 32'h0000_a800);
      if (k >= 5) rd(IDX_WARN, 32'h0000_b000 | (32'h1 << pos[k]));
      `CHK(error_summary_bit, 1'b1)
      apb(1'b1, IDX_CTRL, 32'h0000_0003);
      rd(IDX_ERR, 32'h0000_a000);
    end
    $display("test flags done");
    apb(1'b1, IDX_CFG, 32'h0000_0002);
    ev(8);
    rd(IDX_WARN, 32'h0000_b000);
    ev(5);
    rd(IDX_ERR, 32'h0000_a000);
    apb(1'b1, IDX_CTRL, 32'h0000_0002);
    $display("test masks done");
    {supply_undervolt_err, regulator_undervolt_err} <= 2'b11;
    apb(1'b1, IDX_CTRL, 32'h0000_0001);
    rd(IDX_ERR, 32'h0000_a00c);
    {supply_undervolt_err, regulator_undervolt_err} <= 2'b00;
    apb(1'b1, IDX_CTRL, 32'h0000_0001);
    rd(IDX_ERR, 32'h0000_a000);
    $display("test undervolt done");
    for (int m = 0; m < 2; m++) begin
      turn_eighth_mode <= m[0];
      turn_count <= m ? 12'sd2047 : 12'sd512;
      @(posedge pclk);
      turn_count <= '0;
      apb(1'b1, IDX_CTRL, 32'h0000_0002);
      rd(IDX_WARN, 32'h0000_b001);
      apb(1'b1, IDX_CTRL, 32'h0000_0004);
      rd(IDX_WARN, 32'h0000_b000);
    end
    $display("test turns done");
    wrap_up();
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
endmodule
